// ===== i2c_slave_defs.svh
// address, pointer and bit-slot constants for the register access slave
`ifndef I2C_SLAVE_DEFS_SVH
`define I2C_SLAVE_DEFS_SVH
`define SLV_ADDR_HI 3'h2
`define SLV_ADDR_MID 2'h2
`define REG_COUNT_DEF 32
`define PTR_HOLD_ADDR 8'h00
`define PTR_STEP 8'h01
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define SYNC_RST 4'hc
`endif

// ===== i2c_slave_pkg.sv
// types shared by the register access slave
package i2c_slave_pkg;
   typedef enum logic [2:0] {LS_IDLE, LS_ADDR, LS_REG, LS_WDATA, LS_RDATA} link_state_e;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } reg_write_s;
endpackage : i2c_slave_pkg

// ===== i2c_register_access_slave.sv
// two-wire slave giving a bus master byte access to an 8-bit register space
// Notes on behaviour
// - matching slave address is acknowledged in the ninth bit slot
// - valid register address is acknowledged, invalid one gets not-acknowledge
// - every written data byte is acknowledged before the next byte
// - pointer steps after each written byte, but stays put at 0x00
// - after read address ack, slave shifts out selected register msb first
// - acknowledge holds data line low across the ninth clock high phase
// - not-acknowledge leaves data line released for the whole ninth pulse
// - own address is 010 P 1 0 S from port and address select straps
// - data stable while clock high; changes then are START or STOP
`timescale 1ns/10ps
`include "i2c_slave_defs.svh"

module i2c_register_access_slave
   import i2c_slave_pkg::*;
#(
   parameter int NUM_REGS = `REG_COUNT_DEF
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic port_sel,
   input wire logic address_select_input,
   output logic wr_valid,
   output reg_write_s wr,
   output logic rd_valid,
   output logic [7:0] rd_addr,
   input wire logic [7:0] rd_data
);

   if (NUM_REGS < 1 || NUM_REGS > 256) begin : g_chk
      $error("NUM_REGS must lie in 1..256");
   end

   localparam logic [8:0] REGS_W = 9'(NUM_REGS);

   // link domain, clocked by scl
   logic lr_m_q, lrst_n_q;
   logic [1:0] strap_m_q, strap_q;
   link_state_e st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d;
   logic drive_q, drive_d, rw_q, rw_d, seen_q, seen_d;
   logic rreq_q, rreq_d, wtgl_q, wtgl_d, oe_q;
   reg_write_s wbuf_q, wbuf_d;
   logic is_start;
   logic [7:0] byte_in, next_ptr;
   logic [6:0] own_addr;

   // system domain
   logic [3:0] sync_m_q, sync_s_q, sync_p_q;
   logic start_tgl_q, start_tgl_d, frame_q, frame_d;
   logic wr_valid_q, wr_valid_d, rd_valid_q, rd_valid_d;
   logic [7:0] rd_addr_q, rd_addr_d, rdata_q, rdata_d;
   reg_write_s wr_q, wr_d;
   logic start_det, stop_det, wchg, rchg;

   // nrst reaches the scl domain through two flops; it only acts while scl runs
   always_ff @(posedge scl) begin
      lr_m_q <= nrst;
      lrst_n_q <= lr_m_q;
      strap_m_q <= {port_sel, address_select_input};
      strap_q <= strap_m_q;
   end

   assign own_addr = {`SLV_ADDR_HI, strap_q[1], `SLV_ADDR_MID, strap_q[0]};
   // start toggle is held from START until well past the first scl rise, so one
   // sample suffices; a two-flop chain would lose the first address bits
   assign is_start = start_tgl_q != seen_q;
   assign byte_in = {sh_q[6:0], sda_i};
   assign next_ptr = (ptr_q == `PTR_HOLD_ADDR) ? ptr_q : ptr_q + `PTR_STEP;

   always_comb begin
      logic [3:0] c;
      link_state_e s;
      c = is_start ? 4'h0 : cnt_q;
      s = is_start ? LS_ADDR : st_q;
      st_d = s;
      cnt_d = c;
      sh_d = sh_q;
      tx_d = tx_q;
      ptr_d = ptr_q;
      drive_d = 1'b0;
      rw_d = rw_q;
      rreq_d = rreq_q;
      wtgl_d = wtgl_q;
      wbuf_d = wbuf_q;
      seen_d = start_tgl_q;
      if (s != LS_IDLE) begin
         if (c < `BIT_ACK) begin
            sh_d = byte_in;
            cnt_d = c + 4'h1;
            if (c != `BIT_LAST) begin
               if (s == LS_RDATA) begin
                  drive_d = ~tx_q[6];
                  tx_d = {tx_q[6:0], 1'b0};
               end
            end else begin
               unique case (s)
                  LS_ADDR: begin
                     if (byte_in[7:1] == own_addr) begin
                        drive_d = 1'b1;
                        rw_d = byte_in[0];
                     end else begin
                        st_d = LS_IDLE;
                     end
                  end
                  LS_REG: begin
                     if ({1'b0, byte_in} < REGS_W) begin
                        drive_d = 1'b1;
                        ptr_d = byte_in;
                        rreq_d = ~rreq_q;
                     end else begin
                        st_d = LS_IDLE;
                     end
                  end
                  LS_WDATA: begin
                     drive_d = 1'b1;
                     wbuf_d = '{addr: ptr_q, data: byte_in};
                     wtgl_d = ~wtgl_q;
                     ptr_d = next_ptr;
                     rreq_d = ~rreq_q;
                  end
                  LS_RDATA: drive_d = 1'b0;
                  LS_IDLE: ;
               endcase
            end
         end else begin
            cnt_d = 4'h0;
            unique case (s)
               LS_ADDR: begin
                  if (rw_q) begin
                     st_d = LS_RDATA;
                     tx_d = rdata_q;
                     drive_d = ~rdata_q[7];
                     ptr_d = next_ptr;
                     rreq_d = ~rreq_q;
                  end else begin
                     st_d = LS_REG;
                  end
               end
               LS_REG: st_d = LS_WDATA;
               LS_WDATA: ;
               LS_RDATA: begin
                  if (!sda_i) begin
                     tx_d = rdata_q;
                     drive_d = ~rdata_q[7];
                     ptr_d = next_ptr;
                     rreq_d = ~rreq_q;
                  end else begin
                     st_d = LS_IDLE;
                  end
               end
               LS_IDLE: ;
            endcase
         end
      end
   end

   always_ff @(posedge scl) begin
      if (!lrst_n_q) begin
         st_q <= LS_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         drive_q <= 1'b0;
         rw_q <= 1'b0;
         rreq_q <= 1'b0;
         wtgl_q <= 1'b0;
         wbuf_q <= '0;
         seen_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         tx_q <= tx_d;
         ptr_q <= ptr_d;
         drive_q <= drive_d;
         rw_q <= rw_d;
         rreq_q <= rreq_d;
         wtgl_q <= wtgl_d;
         wbuf_q <= wbuf_d;
         seen_q <= seen_d;
      end
   end

   // the pin changes only after scl falls, so it is stable over the high phase
   always_ff @(negedge scl) begin
      if (!lrst_n_q) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= drive_q;
      end
   end

   assign sda_o = 1'b0;
   // a STOP seen by the system side frees the line even when scl stops mid byte
   assign sda_oe = oe_q & frame_q;

   always_comb begin
      start_det = sync_s_q[3] & sync_p_q[3] & sync_p_q[2] & ~sync_s_q[2];
      stop_det = sync_s_q[3] & sync_p_q[3] & ~sync_p_q[2] & sync_s_q[2];
      wchg = sync_s_q[1] ^ sync_p_q[1];
      rchg = sync_s_q[0] ^ sync_p_q[0];
      start_tgl_d = start_tgl_q ^ start_det;
      frame_d = start_det | (frame_q & ~stop_det);
      wr_valid_d = wchg;
      wr_d = wchg ? wbuf_q : wr_q;
      rd_valid_d = rchg;
      rd_addr_d = rchg ? ptr_q : rd_addr_q;
      rdata_d = rd_valid_q ? rd_data : rdata_q;
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         sync_m_q <= `SYNC_RST;
         sync_s_q <= `SYNC_RST;
         sync_p_q <= `SYNC_RST;
         start_tgl_q <= 1'b0;
         frame_q <= 1'b0;
         wr_valid_q <= 1'b0;
         wr_q <= '0;
         rd_valid_q <= 1'b0;
         rd_addr_q <= 8'h00;
         rdata_q <= 8'h00;
      end else begin
         sync_m_q <= {scl, sda_i, wtgl_q, rreq_q};
         sync_s_q <= sync_m_q;
         sync_p_q <= sync_s_q;
         start_tgl_q <= start_tgl_d;
         frame_q <= frame_d;
         wr_valid_q <= wr_valid_d;
         wr_q <= wr_d;
         rd_valid_q <= rd_valid_d;
         rd_addr_q <= rd_addr_d;
         rdata_q <= rdata_d;
      end
   end

   assign wr_valid = wr_valid_q;
   assign wr = wr_q;
   assign rd_valid = rd_valid_q;
   assign rd_addr = rd_addr_q;

   sequence s_wr_pulse;
      wr_valid ##1 !wr_valid;
   endsequence

   sequence s_fetch;
      rd_valid ##1 (rdata_q == $past(rd_data));
   endsequence

   a_addr_ack_slot: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (st_q == LS_ADDR && cnt_q == `BIT_ACK && !is_start) |-> oe_q)
      else $error("matched address not acknowledged");

   a_reg_nak: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (st_q == LS_REG && cnt_q == `BIT_LAST && !is_start && {1'b0, byte_in} >= REGS_W)
      |=> (st_q == LS_IDLE && !drive_q) ##1 !oe_q)
      else $error("invalid register address not refused");

   a_wdata_ack: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (st_q == LS_WDATA && cnt_q == `BIT_ACK && !is_start) |-> oe_q)
      else $error("write data byte not acknowledged");

   a_ptr_hold_zero: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (st_q == LS_WDATA && cnt_q == `BIT_LAST && !is_start && ptr_q == `PTR_HOLD_ADDR)
      |=> ptr_q == `PTR_HOLD_ADDR)
      else $error("pointer moved off register zero");

   a_ptr_advance: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (st_q == LS_WDATA && cnt_q == `BIT_LAST && !is_start && ptr_q != `PTR_HOLD_ADDR)
      |=> ptr_q == $past(ptr_q) + `PTR_STEP)
      else $error("pointer did not step by one");

   a_rdata_bits: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (st_q == LS_RDATA && cnt_q < `BIT_ACK && !is_start) |-> oe_q != tx_q[7])
      else $error("read bit on the line differs from the shifter");

   a_rdata_load: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (st_q == LS_RDATA && cnt_q == `BIT_ACK && !is_start && !sda_i)
      |=> tx_q == $past(rdata_q))
      else $error("next read byte not loaded after master ack");

   a_nak_release: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (st_q == LS_RDATA && cnt_q == `BIT_ACK && !is_start && sda_i)
      |=> (st_q == LS_IDLE) ##1 !oe_q)
      else $error("line not released after master not-acknowledge");

   a_start_frame: assert property (@(posedge clock) disable iff (!nrst)
      start_det |=> frame_q && start_tgl_q != $past(start_tgl_q))
      else $error("START not registered");

   a_stop_frame: assert property (@(posedge clock) disable iff (!nrst)
      stop_det |=> !frame_q ##0 !sda_oe)
      else $error("STOP did not free the line");

   a_write_strobe: assert property (@(posedge clock) disable iff (!nrst)
      wchg |=> s_wr_pulse)
      else $error("write strobe not a single pulse");

   a_read_fetch: assert property (@(posedge clock) disable iff (!nrst)
      rchg |=> s_fetch)
      else $error("read data not captured after fetch");

endmodule : i2c_register_access_slave

// ===== i2c_master_model.sv
// bus master model: drives the serial clock and pulls the data wire
`timescale 1ns/10ps
module i2c_master_model (
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   int hold_err = 0;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // pulses with data released and no start, so the link side sees reset
   task automatic idle_clocks(input int n);
      repeat (n) begin
         #15 scl = 1'b0;
         #15 scl = 1'b1;
      end
   endtask : idle_clocks
   // 60 ns hold leaves margin over the slave's synchroniser delay
   task automatic start_cond();
      sda_pull = 1'b0;
      #8 scl = 1'b1;
      #20 sda_pull = 1'b1;
      #60 scl = 1'b0;
      #7;
   endtask : start_cond
   task automatic stop_cond();
      sda_pull = 1'b1;
      #8 scl = 1'b1;
      #30 sda_pull = 1'b0;
      #60;
   endtask : stop_cond
   // wire sampled at both ends of the high phase; a change there is counted
   task automatic bit_io(input logic pull, output logic got);
      sda_pull = pull;
      #8 scl = 1'b1;
      got = sda;
      #14 if (sda !== got) hold_err++;
      #1 scl = 1'b0;
      #7;
   endtask : bit_io
   // msb first, then the acknowledge slot; rx is {bits, slot level}
   task automatic byte_io(input logic [7:0] tx, input logic ack_pull, output logic [8:0] rx);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(~tx[i], b);
         rx[i+1] = b;
      end
      bit_io(ack_pull, b);
      rx[0] = b;
   endtask : byte_io
endmodule : i2c_master_model

// ===== i2c_register_access_slave_bench.sv
// self-checking bench for the two-wire register access slave
`timescale 1ns/10ps
module i2c_register_access_slave_bench;
   localparam int NREG = 16;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic port_sel = 1'b0;
   logic address_select_input = 1'b0;
   logic scl, m_pull, sda_line, sda_o, sda_oe, wr_valid, rd_valid;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic [7:0] fetch_addr;
   i2c_slave_pkg::reg_write_s wr;
   i2c_slave_pkg::reg_write_s wq[$];
   int miscompares = 0;
   int cmp_count = 0;
   // open-drain wire with pull-up
   assign sda_line = ~(sda_oe | m_pull);
   // register contents stand-in: a pattern of the address
   assign rd_data = rd_addr ^ 8'h5a;
   always #4 clock = ~clock;
   always @(posedge clock) begin
      if (wr_valid === 1'b1) wq.push_back(wr);
      if (rd_valid === 1'b1) fetch_addr <= rd_addr;
   end
   i2c_master_model mst (.scl(scl), .sda_pull(m_pull), .sda(sda_line));
   i2c_register_access_slave #(.NUM_REGS(NREG)) dut_u (
      .clock(clock), .nrst(nrst), .scl(scl), .sda_i(sda_line), .sda_o(sda_o),
      .sda_oe(sda_oe), .port_sel(port_sel), .address_select_input(address_select_input),
      .wr_valid(wr_valid), .wr(wr), .rd_valid(rd_valid), .rd_addr(rd_addr), .rd_data(rd_data)
   );
   task automatic close_out();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_bit(input logic got, input logic exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask : chk_bit
   // ack is 1 where the slave should pull the slot low
   task automatic send(input logic [7:0] b, input logic ack);
      logic [8:0] rx;
      mst.byte_io(b, 1'b0, rx);
      chk_bit(rx[0], ~ack);
   endtask : send
   function automatic logic [7:0] step(input logic [7:0] p);
      return (p == 8'h00) ? 8'h00 : p + 8'h01;
   endfunction : step
   function automatic logic [7:0] own(input logic p, input logic s, input logic rd);
      return {3'b010, p, 2'b10, s, rd};
   endfunction : own
   // the link side takes reset through two scl flops, so it needs idle pulses
   // while nrst is low and again after release before the first START
   task automatic do_reset();
      @(posedge clock);
      nrst <= 1'b0;
      fork
         mst.idle_clocks(4);
         repeat (8) @(posedge clock);
      join
      chk({8'h00, rd_addr}, 16'h0000);
      chk_bit(sda_oe, 1'b0);
      @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      mst.idle_clocks(3);
   endtask : do_reset
   task automatic t_addresses();
      for (int k = 0; k < 4; k++) begin
         @(posedge clock);
         port_sel <= k[1];
         address_select_input <= k[0];
         mst.start_cond();
         send(own(k[1], k[0], 1'b0), 1'b1);
         mst.stop_cond();
         mst.start_cond();
         send(own(k[1], ~k[0], 1'b0), 1'b0);
         mst.stop_cond();
      end
      @(posedge clock);
      port_sel <= 1'b0;
      address_select_input <= 1'b0;
   endtask : t_addresses
   task automatic t_write(input logic [7:0] r, input int n);
      logic [7:0] p;
      wq.delete();
      p = r;
      mst.start_cond();
      send(own(1'b0, 1'b0, 1'b0), 1'b1);
      send(r, 1'b1);
      for (int i = 0; i < n; i++) begin
         send(8'hc3 + i[7:0], 1'b1);
      end
      mst.stop_cond();
      for (int k = 0; k < 40 && wq.size() < n; k++) @(posedge clock);
      chk(16'(wq.size()), 16'(n));
      for (int i = 0; i < n && i < wq.size(); i++) begin
         chk(wq[i], {p, 8'hc3 + i[7:0]});
         p = step(p);
      end
   endtask : t_write
   // data after a refused register byte must be ignored too
   task automatic t_bad_reg();
      wq.delete();
      mst.start_cond();
      send(own(1'b0, 1'b0, 1'b0), 1'b1);
      send(8'(NREG), 1'b0);
      send(8'h77, 1'b0);
      mst.stop_cond();
      repeat (20) @(posedge clock);
      chk(16'(wq.size()), 16'h0000);
   endtask : t_bad_reg
   task automatic t_read(input logic [7:0] r, input int n);
      logic [8:0] rx;
      logic [7:0] p;
      p = r;
      mst.start_cond();
      send(own(1'b0, 1'b0, 1'b0), 1'b1);
      send(r, 1'b1);
      mst.start_cond();
      send(own(1'b0, 1'b0, 1'b1), 1'b1);
      for (int i = 0; i < n; i++) begin
         mst.byte_io(8'hff, i < n - 1, rx);
         chk({8'h00, rx[8:1]}, {8'h00, p ^ 8'h5a});
         p = step(p);
      end
      chk_bit(rx[0], 1'b1);
      mst.stop_cond();
      chk_bit(sda_oe, 1'b0);
      chk_bit(sda_o, 1'b0);
      chk({8'h00, fetch_addr}, {8'h00, p});
   endtask : t_read
   initial begin
      do_reset();
      t_addresses();
      t_write(8'h0d, 3);
      do_reset();
      t_write(8'h00, 2);
      t_bad_reg();
      t_read(8'h03, 3);
      t_read(8'h00, 2);
      t_read(8'h09, 1);
      chk(16'(mst.hold_err), 16'h0000);
      close_out();
   end
   // the tests take about 13 us; a hang is cut well after that
   initial begin
      #200000;
      miscompares++;
      close_out();
   end
endmodule : i2c_register_access_slave_bench
